// File: verilog/line_ctl_pkg.sv
// Constants, register map and types for the serial line-control block
package line_ctl_pkg;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_FLOW_MODE   = 8'h00;
  localparam logic [7:0] OFS_PIN_MODE    = 8'h04;
  localparam logic [7:0] OFS_PIN_DIR     = 8'h08;
  localparam logic [7:0] OFS_PIN_OUT     = 8'h0C;
  localparam logic [7:0] OFS_RESUME_CHAR = 8'h10;
  localparam logic [7:0] OFS_PAUSE_CHAR  = 8'h14;
  localparam logic [7:0] OFS_TURNAROUND  = 8'h18;
  localparam logic [7:0] OFS_STATUS      = 8'h1C;

  // ==========================================================
  // Reset values
  localparam logic [3:0] RST_FLOW_MODE   = 4'h0;
  localparam logic [3:0] RST_PIN_MODE    = 4'h0;
  localparam logic [5:0] RST_PIN_DIR     = 6'h00;
  localparam logic [5:0] RST_PIN_OUT     = 6'h00;
  localparam logic [7:0] RST_RESUME_CHAR = 8'h11;
  localparam logic [7:0] RST_PAUSE_CHAR  = 8'h13;
  localparam logic [3:0] RST_TURNAROUND  = 4'h0;

  // ==========================================================
  // Field values and positions
  localparam logic [2:0] FLOW_HW       = 3'h1;
  localparam logic [2:0] FLOW_SW       = 3'h2;
  localparam logic [2:0] FLOW_MD_FREE  = 3'h3;
  localparam logic [2:0] FLOW_MD_MATCH = 3'h4;
  localparam int         FLOW_HDX_BIT  = 3;
  localparam logic [2:0] PIN_REQ_CLR   = 3'h1;
  localparam logic [2:0] PIN_RDY_SET   = 3'h2;
  localparam logic [2:0] PIN_DIR_A     = 3'h3;
  localparam logic [2:0] PIN_DIR_B     = 3'h4;
  localparam int         PIN_POL_BIT   = 3;
  localparam int         PIN_REQ       = 5;
  localparam int         PIN_CLR       = 4;
  localparam int         PIN_RDY       = 3;
  localparam int         PIN_SET       = 2;
  localparam int         PIN_WAKE      = 0;
  localparam int         ST_RTS_HOLD   = 6;
  localparam int         ST_PAUSED     = 7;
  localparam int         ST_MATCHED    = 8;
  localparam int         ST_RX_BLOCKED = 9;
  localparam int         ST_SUSPENDED  = 10;
  localparam int         ST_DIR_ACTIVE = 11;

  // ==========================================================
  // Timing
  localparam int unsigned CLK_PERIOD_NS       = 4;
  localparam int unsigned SUSPEND_IDLE_MS     = 3;
  localparam int unsigned WAKE_GUARD_MS       = 5;
  localparam int unsigned SUSPEND_IDLE_CYCLES = SUSPEND_IDLE_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned WAKE_GUARD_CYCLES   = WAKE_GUARD_MS * 1000000 / CLK_PERIOD_NS;
  localparam int          SUSP_CNT_W          = 21;
  localparam int          RTS_HEADROOM        = 32;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {DIR_IDLE, DIR_DRIVE, DIR_HOLD} dir_state_e;

  typedef struct packed {
    logic pending;                     // Character waiting to start
    logic busy;                        // Character on the line
  } tx_status_s;

  typedef struct packed {
    logic       valid;                 // One-cycle strobe
    logic [8:0] data;                  // Bit 8 is ninth or parity bit
  } rx_char_s;

  typedef struct packed {
    logic [5:0]            s1;
    logic [5:0]            s2;
    logic [5:0]            s3;
    logic [5:0]            pins;
    logic [3:0]            flow_mode;
    logic [3:0]            pin_mode;
    logic [5:0]            pin_dir;
    logic [5:0]            pin_out;
    logic [7:0]            resume_char;
    logic [7:0]            pause_char;
    logic [3:0]            turnaround;
    logic                  dphase_wr;
    logic [7:0]            dphase_addr;
    logic [31:0]           rdata;
    logic                  rts_hold;
    logic                  paused;
    logic                  matched;
    logic                  rx_blocked;
    dir_state_e            dir_st;
    logic [3:0]            dir_cnt;
    logic                  suspended;
    logic                  guard_done;
    logic [SUSP_CNT_W-1:0] susp_cnt;
    logic                  wake_req;
  } state_s;

endpackage

// File: verilog/uart_flow_line_control.sv
// Flow control, pin roles, transceiver direction, address filter and suspend logic
//
// Design decisions made here: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
module uart_flow_line_control #(
  parameter int unsigned IDLE_CYCLES  = line_ctl_pkg::SUSPEND_IDLE_CYCLES,
  parameter int unsigned GUARD_CYCLES = line_ctl_pkg::WAKE_GUARD_CYCLES,
  parameter int          RX_DEPTH     = 384,
  parameter int          FILL_W       = 9
) (
  input  wire logic                     hclk,
  input  wire logic                     hresetn,
  input  wire logic                     hsel,
  input  wire logic [31:0]              haddr,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic [2:0]               hsize,
  input  wire logic [31:0]              hwdata,
  input  wire logic                     hready,
  output logic                          hreadyout,
  output logic                          hresp,
  output logic [31:0]                   hrdata,
  input  wire logic [5:0]               gpio_in,
  output logic [5:0]                    gpio_out,
  output logic [5:0]                    gpio_oe,
  input  wire line_ctl_pkg::tx_status_s tx_stat,
  input  wire line_ctl_pkg::rx_char_s   rx_in,
  input  wire logic                     bit_tick,
  input  wire logic [FILL_W-1:0]        rx_fill,
  output logic                          tx_allow,
  output logic                          rx_store,
  input  wire logic                     usb_activity,
  input  wire logic                     wake_cap,
  input  wire logic                     host_wake_en,
  output logic                          suspended,
  output logic                          remote_wake
);
  import line_ctl_pkg::*;

  localparam logic [FILL_W-1:0]     RTS_HI     = FILL_W'(RX_DEPTH - RTS_HEADROOM);
  localparam logic [FILL_W-1:0]     RTS_LO     = FILL_W'(RX_DEPTH / 2);
  localparam logic [SUSP_CNT_W-1:0] IDLE_LAST  = SUSP_CNT_W'(IDLE_CYCLES - 1);
  localparam logic [SUSP_CNT_W-1:0] GUARD_LAST = SUSP_CNT_W'(GUARD_CYCLES - 1);

  state_s st;
  state_s next_st;

  logic [2:0]  flow_sel;
  logic [2:0]  pin_sel;
  logic        hw_flow;
  logic        sw_flow;
  logic        md_mode;
  logic        rs485;
  logic        clr_n;
  logic        dir_level;
  logic        rx_ok;
  logic        addr_hit;
  logic        wake_fall;
  logic        addr_phase;
  logic [31:0] status_word;

  // ==========================================================
  // Mode decode
  assign flow_sel = st.flow_mode[2:0];
  assign pin_sel  = st.pin_mode[2:0];
  assign sw_flow  = (flow_sel == FLOW_SW);
  assign hw_flow  = (flow_sel == FLOW_HW) &&
                    ((pin_sel == PIN_REQ_CLR) || (pin_sel == PIN_RDY_SET));
  assign md_mode  = (flow_sel == FLOW_MD_FREE) || (flow_sel == FLOW_MD_MATCH);
  assign rs485    = (pin_sel == PIN_DIR_A) || (pin_sel == PIN_DIR_B);

  // Clear input of the active pin pair, active low
  assign clr_n = (pin_sel == PIN_RDY_SET) ? st.pins[PIN_SET] : st.pins[PIN_CLR];

  // Direction level with optional inversion
  assign dir_level = (st.dir_st != DIR_IDLE) ^ st.pin_mode[PIN_POL_BIT];

  // ==========================================================
  // Receive path qualification
  assign rx_ok    = rx_in.valid && !(st.flow_mode[FLOW_HDX_BIT] && tx_stat.busy);
  assign addr_hit = (rx_in.data[7:0] == st.resume_char) ||
                    (rx_in.data[7:0] == st.pause_char);
  assign rx_store = rx_ok && !(md_mode && (rx_in.data[8] || st.rx_blocked));

  // ==========================================================
  // Transmit gate: only the start of a character is held back
  always_comb begin
    tx_allow = 1'b1;
    if (hw_flow && clr_n) begin
      tx_allow = 1'b0;
    end
    if (sw_flow && st.paused) begin
      tx_allow = 1'b0;
    end
    if ((flow_sel == FLOW_MD_MATCH) && !st.matched) begin
      tx_allow = 1'b0;
    end
    if (rs485 && (st.dir_st == DIR_IDLE)) begin
      tx_allow = 1'b0;
    end
  end

  // ==========================================================
  // Pin roles and drive
  always_comb begin
    gpio_oe  = st.pin_dir;
    gpio_out = st.pin_out;
    case (pin_sel)
      PIN_REQ_CLR: begin
        gpio_oe[PIN_REQ]  = 1'b1;
        gpio_out[PIN_REQ] = hw_flow && st.rts_hold;
        gpio_oe[PIN_CLR]  = 1'b0;
      end
      PIN_RDY_SET: begin
        gpio_oe[PIN_RDY]  = 1'b1;
        gpio_out[PIN_RDY] = hw_flow && st.rts_hold;
        gpio_oe[PIN_SET]  = 1'b0;
      end
      PIN_DIR_A, PIN_DIR_B: begin
        gpio_oe[PIN_REQ]  = 1'b1;
        gpio_out[PIN_REQ] = dir_level;
      end
      default: begin
      end
    endcase
  end

  // ==========================================================
  // Bus side
  assign addr_phase = hsel && hready && htrans[1];
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign hrdata     = st.rdata;
  assign suspended  = st.suspended;
  assign remote_wake = st.wake_req;
  assign wake_fall  = st.pins[PIN_WAKE] && (st.s2[PIN_WAKE] == st.s3[PIN_WAKE]) &&
                      !st.s2[PIN_WAKE];

  // Status word
  always_comb begin
    status_word                = 32'h0000_0000;
    status_word[5:0]           = st.pins;
    status_word[ST_RTS_HOLD]   = st.rts_hold;
    status_word[ST_PAUSED]     = st.paused;
    status_word[ST_MATCHED]    = st.matched;
    status_word[ST_RX_BLOCKED] = st.rx_blocked;
    status_word[ST_SUSPENDED]  = st.suspended;
    status_word[ST_DIR_ACTIVE] = (st.dir_st != DIR_IDLE);
  end

  // ==========================================================
  // Next-state logic
  always_comb begin
    next_st = st;

    // Pin synchroniser; a change counts when stages two and three agree
    next_st.s1 = gpio_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < 6; i++) begin
      if (st.s2[i] == st.s3[i]) begin
        next_st.pins[i] = st.s2[i];
      end
    end

    // Address phase capture and read data
    next_st.dphase_wr = addr_phase && hwrite;
    if (addr_phase) begin
      next_st.dphase_addr = haddr[7:0];
    end
    if (addr_phase && !hwrite) begin
      if (haddr[7:0] == OFS_FLOW_MODE) begin
        next_st.rdata = {28'h0000000, st.flow_mode};
      end else if (haddr[7:0] == OFS_PIN_MODE) begin
        next_st.rdata = {28'h0000000, st.pin_mode};
      end else if (haddr[7:0] == OFS_PIN_DIR) begin
        next_st.rdata = {26'h0, st.pin_dir};
      end else if (haddr[7:0] == OFS_PIN_OUT) begin
        next_st.rdata = {26'h0, st.pin_out};
      end else if (haddr[7:0] == OFS_RESUME_CHAR) begin
        next_st.rdata = {24'h000000, st.resume_char};
      end else if (haddr[7:0] == OFS_PAUSE_CHAR) begin
        next_st.rdata = {24'h000000, st.pause_char};
      end else if (haddr[7:0] == OFS_TURNAROUND) begin
        next_st.rdata = {28'h0000000, st.turnaround};
      end else if (haddr[7:0] == OFS_STATUS) begin
        next_st.rdata = status_word;
      end else begin
        next_st.rdata = 32'h0000_0000;
      end
    end

    // Data phase write
    if (st.dphase_wr) begin
      if (st.dphase_addr == OFS_FLOW_MODE) begin
        next_st.flow_mode = hwdata[3:0];
      end else if (st.dphase_addr == OFS_PIN_MODE) begin
        next_st.pin_mode = hwdata[3:0];
      end else if (st.dphase_addr == OFS_PIN_DIR) begin
        next_st.pin_dir = hwdata[5:0];
      end else if (st.dphase_addr == OFS_PIN_OUT) begin
        next_st.pin_out = hwdata[5:0];
      end else if (st.dphase_addr == OFS_RESUME_CHAR) begin
        next_st.resume_char = hwdata[7:0];
      end else if (st.dphase_addr == OFS_PAUSE_CHAR) begin
        next_st.pause_char = hwdata[7:0];
      end else if (st.dphase_addr == OFS_TURNAROUND) begin
        next_st.turnaround = hwdata[3:0];
      end
    end

    // Request line hysteresis on receive fill level
    if (rx_fill >= RTS_HI) begin
      next_st.rts_hold = 1'b1;
    end else if (rx_fill <= RTS_LO) begin
      next_st.rts_hold = 1'b0;
    end

    // In-band pause and resume
    if (sw_flow && rx_ok) begin
      if (rx_in.data[7:0] == st.pause_char) begin
        next_st.paused = 1'b1;
      end else if (rx_in.data[7:0] == st.resume_char) begin
        next_st.paused = 1'b0;
      end
    end

    // Multidrop address filter
    if (md_mode && rx_ok && rx_in.data[8]) begin
      next_st.matched    = addr_hit;
      next_st.rx_blocked = !addr_hit;
    end

    // Transceiver direction sequencing
    case (st.dir_st)
      DIR_IDLE: begin
        if (rs485 && tx_stat.pending) begin
          next_st.dir_st = DIR_DRIVE;
        end
      end
      DIR_DRIVE: begin
        if (!tx_stat.pending && !tx_stat.busy) begin
          next_st.dir_cnt = 4'h0;
          if (st.turnaround == 4'h0) begin
            next_st.dir_st = DIR_IDLE;
          end else begin
            next_st.dir_st = DIR_HOLD;
          end
        end
      end
      DIR_HOLD: begin
        if (tx_stat.pending) begin
          next_st.dir_st = DIR_DRIVE;
        end else if (bit_tick) begin
          if (st.dir_cnt + 4'h1 >= st.turnaround) begin
            next_st.dir_st = DIR_IDLE;
          end else begin
            next_st.dir_cnt = st.dir_cnt + 4'h1;
          end
        end
      end
      default: begin
        next_st.dir_st = DIR_IDLE;
      end
    endcase
    if (!rs485) begin
      next_st.dir_st = DIR_IDLE;
    end

    // Suspend detection and wakeup guard
    next_st.wake_req = 1'b0;
    if (usb_activity) begin
      next_st.susp_cnt   = '0;
      next_st.suspended  = 1'b0;
      next_st.guard_done = 1'b0;
    end else if (!st.suspended) begin
      if (st.susp_cnt == IDLE_LAST) begin
        next_st.suspended = 1'b1;
        next_st.susp_cnt  = '0;
      end else begin
        next_st.susp_cnt = st.susp_cnt + 1'b1;
      end
    end else if (!st.guard_done) begin
      if (st.susp_cnt == GUARD_LAST) begin
        next_st.guard_done = 1'b1;
      end else begin
        next_st.susp_cnt = st.susp_cnt + 1'b1;
      end
    end else begin
      next_st.wake_req = wake_fall && !st.pin_dir[PIN_WAKE] &&
                         wake_cap && host_wake_en;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st             <= '0;
      st.s1          <= 6'h3F;
      st.s2          <= 6'h3F;
      st.s3          <= 6'h3F;
      st.pins        <= 6'h3F;
      st.flow_mode   <= RST_FLOW_MODE;
      st.pin_mode    <= RST_PIN_MODE;
      st.pin_dir     <= RST_PIN_DIR;
      st.pin_out     <= RST_PIN_OUT;
      st.resume_char <= RST_RESUME_CHAR;
      st.pause_char  <= RST_PAUSE_CHAR;
      st.turnaround  <= RST_TURNAROUND;
      st.dir_st      <= DIR_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  chk_pins_input_reset: assert property (
    (st.pin_mode == RST_PIN_MODE) && (st.pin_dir == RST_PIN_DIR) |-> (gpio_oe == 6'h00))
    else $error("pins driven while all configured as inputs");

  chk_dir_pin_drive: assert property (
    rs485 |-> gpio_oe[PIN_REQ])
    else $error("direction pin not driven in transceiver mode");

  chk_dir_polarity: assert property (
    rs485 && (st.dir_st == DIR_DRIVE) |-> (gpio_out[PIN_REQ] == !st.pin_mode[PIN_POL_BIT]))
    else $error("direction pin polarity wrong");

  chk_dir_before_send: assert property (
    rs485 && tx_allow |-> (st.dir_st != DIR_IDLE))
    else $error("transmit allowed before direction asserted");

  chk_req_follows_fill: assert property (
    rx_fill >= RTS_HI |=> st.rts_hold)
    else $error("request line not dropped at high fill");

  chk_clear_stalls_tx: assert property (
    hw_flow && clr_n |-> !tx_allow)
    else $error("transmit allowed while clear deasserted");

  chk_pause_char_stop: assert property (
    sw_flow && rx_ok && (rx_in.data[7:0] == st.pause_char) && !st.dphase_wr |=> !tx_allow)
    else $error("pause character did not stop transmit");

  chk_resume_char_go: assert property (
    sw_flow && rx_ok && (rx_in.data[7:0] == st.resume_char) &&
    (rx_in.data[7:0] != st.pause_char) |=> !st.paused)
    else $error("resume character did not clear pause");

  chk_addr_not_stored: assert property (
    md_mode && rx_in.valid && rx_in.data[8] |-> !rx_store)
    else $error("address character stored");

  chk_mismatch_blocks: assert property (
    md_mode && rx_ok && rx_in.data[8] && !addr_hit |=> st.rx_blocked ##0 !st.matched)
    else $error("unmatched address left receiver enabled");

  chk_mode4_needs_match: assert property (
    (flow_sel == FLOW_MD_MATCH) && !st.matched |-> !tx_allow)
    else $error("mode 4 transmit before address match");

  chk_half_duplex_rx: assert property (
    st.flow_mode[FLOW_HDX_BIT] && tx_stat.busy |-> !rx_store)
    else $error("receive stored while transmitting in half duplex");

  chk_wake_guard_hold: assert property (
    $rose(st.suspended) |-> !remote_wake [*8])
    else $error("wakeup signalled right after suspend entry");

  chk_wake_conditions: assert property (
    remote_wake |-> $past(st.guard_done) && wake_cap && host_wake_en && st.suspended)
    else $error("wakeup without its enables");

  cov_sw_paused: cover property (sw_flow && st.paused && tx_stat.pending);
  cov_dir_hold: cover property (st.dir_st == DIR_HOLD ##1 st.dir_st == DIR_IDLE);
  cov_addr_match: cover property (md_mode && st.matched && rx_store);
  cov_remote_wake: cover property (st.suspended && remote_wake);

endmodule

// File: sim/far_station.sv
// Remote serial station model: received characters and clear line
`timescale 1ns/1ps
module far_station (
  input  wire logic           hclk,
  output line_ctl_pkg::rx_char_s rx_in,
  output logic                clr_pin
);
  import line_ctl_pkg::*;
  initial begin
    rx_in = '0;
    clr_pin = 1'b0;
  end
  // One-cycle strobe; afterwards data shows the inverse, not a stale copy
  task automatic send(input logic [8:0] c);
    @(posedge hclk);
    rx_in <= '{valid: 1'b1, data: c};
    @(posedge hclk);
    rx_in <= '{valid: 1'b0, data: ~c};
  endtask
  // High holds the local transmitter to spare our receive buffer
  task automatic set_clr(input logic v);
    @(posedge hclk);
    clr_pin <= v;
  endtask
endmodule

// File: sim/tb_uart_flow_line_control.sv
// Testbench for the serial line-control block
`timescale 1ns/1ps
module tb_uart_flow_line_control;
  import line_ctl_pkg::*;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0]  htrans = 2'h0;
  logic        hreadyout, hresp, tx_allow, rx_store, suspended, remote_wake, clr_pin;
  logic        wake_pin = 1'b1, usb_act = 1'b1, tick = 1'b0, probe = 1'b0;
  logic        rd_ph = 1'b0, wake_seen = 1'b0;
  logic        wake_cap = 1'b1, host_en = 1'b1;
  logic [5:0]  pin_lvl = 6'h3F;
  logic [5:0]  gpio_out, gpio_oe;
  tx_status_s  tx_stat = '0;
  rx_char_s    rx_in;
  logic [8:0]  rx_fill = 9'h000, ch;
  logic [15:0] seed = 16'h57AE;
  logic [31:0] rd_q[$];
  logic [5:0]  sig_q[$];
  int          fails = 0, cmp_count = 0, cyc = 0;
  logic [8:0]  md_c[6] = '{9'h105, 9'h000, 9'h1AA, 9'h000, 9'h17E, 9'h000};
  logic        md_s[6] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
  wire  [5:0]  sig = {wake_seen, tx_allow, rx_store, suspended, gpio_out[5], gpio_oe[5]};
  always #2 hclk = ~hclk;
  far_station i_far (.hclk(hclk), .rx_in(rx_in), .clr_pin(clr_pin));
  uart_flow_line_control #(.IDLE_CYCLES(20), .GUARD_CYCLES(30)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .gpio_in({pin_lvl[5], clr_pin, pin_lvl[3:1], wake_pin}), .gpio_out(gpio_out),
    .gpio_oe(gpio_oe),
    .tx_stat(tx_stat), .rx_in(rx_in), .bit_tick(tick), .rx_fill(rx_fill),
    .tx_allow(tx_allow), .rx_store(rx_store), .usb_activity(usb_act), .wake_cap(wake_cap),
    .host_wake_en(host_en), .suspended(suspended), .remote_wake(remote_wake));
  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task close_out();
    if (fails == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Single AHB transfer; read expectation noted for the watcher
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    if (!w) rd_q.push_back(e);
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask
  task look(input logic [5:0] e);
    @(posedge hclk);
    probe <= 1'b1;
    sig_q.push_back(e);
    @(posedge hclk);
    probe <= 1'b0;
  endtask
  task rx_chk(input logic [8:0] c, input logic [5:0] e);
    fork
      i_far.send(c);
      look(e);
    join
  endtask
  // Bit tick every eight cycles, wake pulse catcher, data-phase tracker, timeout
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    tick <= (cyc % 8 == 0);
    wake_seen <= wake_seen | remote_wake;
    rd_ph <= hsel & htrans[1] & ~hwrite;
    if (cyc == 4000) begin
      fails++;
      close_out();
    end
  end
  // Compare settled outputs with the oldest note
  always @(negedge hclk) begin
    if (rd_ph) chk(hrdata, rd_q.pop_front());
    if (rd_ph) chk({31'h0, hresp}, 32'h0);
    if (probe) chk({26'h0, sig}, {26'h0, sig_q.pop_front()});
  end
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(0, OFS_RESUME_CHAR, 0, {24'h0, RST_RESUME_CHAR});
    ahb(0, OFS_PAUSE_CHAR, 0, {24'h0, RST_PAUSE_CHAR});
    ahb(0, OFS_PIN_DIR, 0, 32'h0);
    ahb(0, 8'h20, 0, 32'h0);
    look(6'h10);
    // Hardware handshake on pins 5 and 4
    ahb(1, OFS_FLOW_MODE, {29'h0, FLOW_HW}, 0);
    ahb(1, OFS_PIN_MODE, {29'h0, PIN_REQ_CLR}, 0);
    look(6'h11);
    rx_fill <= 9'h160;
    look(6'h13);
    rx_fill <= 9'h0C0;
    look(6'h11);
    seed = nx(seed);
    rx_chk({1'b0, seed[7:0]}, 6'h19);
    i_far.set_clr(1'b1);
    repeat (4) @(posedge hclk);
    look(6'h01);
    i_far.set_clr(1'b0);
    repeat (4) @(posedge hclk);
    look(6'h11);
    // Ready pair on pins 3 and 2: pin 2 high holds the transmitter
    ahb(1, OFS_PIN_MODE, {29'h0, PIN_RDY_SET}, 0);
    look(6'h00);
    pin_lvl[2] <= 1'b0;
    repeat (4) @(posedge hclk);
    look(6'h10);
    // In-band pause and resume
    ahb(1, OFS_FLOW_MODE, {29'h0, FLOW_SW}, 0);
    ahb(1, OFS_PIN_MODE, 0, 0);
    rx_chk(9'h013, 6'h18);
    look(6'h00);
    rx_chk(9'h011, 6'h08);
    look(6'h10);
    // Transceiver direction with a two bit-time hold
    ahb(1, OFS_FLOW_MODE, 0, 0);
    ahb(1, OFS_TURNAROUND, 32'h2, 0);
    ahb(1, OFS_PIN_MODE, {29'h0, PIN_DIR_A}, 0);
    tx_stat <= '{pending: 1'b1, busy: 1'b0};
    @(posedge hclk);
    tx_stat <= '{pending: 1'b0, busy: 1'b1};
    look(6'h13);
    tx_stat <= '0;
    look(6'h13);
    repeat (20) @(posedge hclk);
    look(6'h01);
    ahb(1, OFS_PIN_MODE, {28'h0, 1'b1, PIN_DIR_B}, 0);
    look(6'h03);
    // Multidrop filtering in mode 3
    ahb(1, OFS_PIN_MODE, 0, 0);
    ahb(1, OFS_RESUME_CHAR, 32'h05, 0);
    ahb(1, OFS_PAUSE_CHAR, 32'h7E, 0);
    ahb(1, OFS_FLOW_MODE, {29'h0, FLOW_MD_FREE}, 0);
    for (int i = 0; i < 6; i++) begin
      seed = nx(seed);
      ch = md_c[i][8] ? md_c[i] : {1'b0, seed[7:0]};
      rx_chk(ch, {2'b01, md_s[i], 3'b000});
    end
    // Mode 4: transmit only after an address match, then half duplex blanking
    ahb(1, OFS_FLOW_MODE, {29'h0, FLOW_MD_MATCH}, 0);
    rx_chk(9'h1AA, 6'h10);
    look(6'h00);
    rx_chk(9'h17E, 6'h00);
    look(6'h10);
    ahb(1, OFS_FLOW_MODE, 32'hB, 0);
    tx_stat <= '{pending: 1'b0, busy: 1'b1};
    rx_chk(9'h033, 6'h10);
    tx_stat <= '0;
    // Suspend, guarded wake, then wake request
    usb_act <= 1'b0;
    repeat (25) @(posedge hclk);
    look(6'h14);
    wake_pin <= 1'b0;
    repeat (6) @(posedge hclk);
    wake_pin <= 1'b1;
    look(6'h14);
    repeat (30) @(posedge hclk);
    host_en <= 1'b0;
    wake_pin <= 1'b0;
    repeat (6) @(posedge hclk);
    look(6'h14);
    wake_pin <= 1'b1;
    host_en <= 1'b1;
    wake_cap <= 1'b0;
    repeat (6) @(posedge hclk);
    wake_pin <= 1'b0;
    repeat (6) @(posedge hclk);
    look(6'h14);
    wake_pin <= 1'b1;
    wake_cap <= 1'b1;
    repeat (6) @(posedge hclk);
    wake_pin <= 1'b0;
    repeat (6) @(posedge hclk);
    look(6'h34);
    close_out();
  end
endmodule
